// ==== rtl/ssp_clkgen.v ====
// Master shift clock divider: emits a one-cycle tick every HALF_DIV
// cycles of ref_clk while run is high; each tick is one half period.
// Assumes run is a same-domain level; the count restarts when it falls.
`timescale 1ns/1ps

module ssp_clkgen #(
   parameter [7:0] HALF_DIV = 8'd4
) (
   input  wire ref_clk,  // System clock
   input  wire rst_n,    // Synchronous reset, active low
   input  wire clk_en,   // Freezes the counter while low
   input  wire run,      // Count while high
   output reg  tick_q    // One-cycle half period pulse
);

   reg [7:0] cnt_q;

   // ---------------------------------------------------------------
   // Half period counter; restart keeps the first half period full
   // ---------------------------------------------------------------
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         cnt_q  <= 8'h00;
         tick_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!run)
         begin
            cnt_q  <= 8'h00;
            tick_q <= 1'b0;
         end
         else if (cnt_q == HALF_DIV - 8'd1)
         begin
            cnt_q  <= 8'h00;
            tick_q <= 1'b1;
         end
         else
         begin
            cnt_q  <= cnt_q + 8'd1;
            tick_q <= 1'b0;
         end
      end
   end

endmodule // ssp_clkgen

// ==== rtl/ssp_consts.vh ====
// Constants for the synchronous serial port core: register offsets,
// field positions, reset values and the default shift clock divider.
// Assumes a 32-bit APB register bus and a 40 MHz ref_clk.
//
// Function
// - Data shifts through a 16-bit shift register, reached via a buffer.
// - Link uses data in, data out, shift clock and active-low select.
// - Master drives the shift clock; slave takes it as an input.
// - Enable bit activates the module and claims its pins; clear disables.
// - Idle-stop bit halts the module while the system is idle.
// - Word arriving while previous is unread is dropped; overflow set.
// - Writing the buffer loads transmit holding stage and sets tx-full.
// - Moving holding stage into shift register clears tx-full.
// - Reception sets rx-full; reading the buffer clears it.
// - Master clock pin disable stops internal shift clock, pin freed.
// - Clock polarity bit sets idle level: one high, zero low.
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SSP_OFF_STAT        8'h00
`define SSP_OFF_CON1        8'h04
`define SSP_OFF_BUF         8'h08
`define SSP_OFF_IRQ_STAT    8'h0c
`define SSP_OFF_IRQ_MASK    8'h10

// ----------------------------------------------------------------------
// Status and control register fields
// ----------------------------------------------------------------------
`define SSP_STAT_MODULE_ENABLE  15
`define SSP_STAT_IDLE_STOP      13
`define SSP_STAT_RX_OVERFLOW    6
`define SSP_STAT_TX_FULL        1
`define SSP_STAT_RX_FULL        0

// ----------------------------------------------------------------------
// Control register one fields
// ----------------------------------------------------------------------
`define SSP_CON1_CLOCK_PIN_DISABLE    12
`define SSP_CON1_DATA_OUT_PIN_DISABLE 11
`define SSP_CON1_WORD_WIDTH_SELECT    10
`define SSP_CON1_INPUT_SAMPLE_PHASE   9
`define SSP_CON1_CLOCK_EDGE_SELECT    8
`define SSP_CON1_SELECT_PIN_ENABLE    7
`define SSP_CON1_CLOCK_IDLE_POLARITY  6
`define SSP_CON1_MASTER_ENABLE        5
`define SSP_CON1_WIDTH                13
`define SSP_CON1_RESET                13'h0000

// ----------------------------------------------------------------------
// Interrupt status and mask bits
// ----------------------------------------------------------------------
`define SSP_IRQ_RX_DONE     0
`define SSP_IRQ_TX_START    1
`define SSP_IRQ_OVERFLOW    2
`define SSP_IRQ_WIDTH       3

// ----------------------------------------------------------------------
// Data path and timing
// ----------------------------------------------------------------------
`define SSP_WORD_BITS       5'd16
`define SSP_BYTE_BITS       5'd8
`define SSP_HALF_DIV        8'd4

`endif

// ==== rtl/ssp_core.v ====
// Synchronous serial port core with an APB register slave, a 16-bit
// shift register, transmit and receive holding stages and one interrupt.
// Assumes pins are joined to the link through outside pad logic and that
// cpu_idle comes from logic on ref_clk.
`timescale 1ns/1ps
`include "ssp_consts.vh"

module ssp_core #(
   parameter [7:0] HALF_DIV = `SSP_HALF_DIV
) (
   input  wire        ref_clk,             // System clock, 40 MHz
   input  wire        rst_n,               // Synchronous reset, active low
   input  wire        clk_en,              // Freezes all state while low
   input  wire        cpu_idle,            // System idle mode level
   input  wire        psel,                // APB select
   input  wire        penable,             // APB access phase
   input  wire        pwrite,              // APB direction, high writes
   input  wire [7:0]  paddr,               // APB byte address
   input  wire [31:0] pwdata,              // APB write data
   output reg  [31:0] prdata_q,            // APB read data
   output reg         pready_q,            // APB ready
   output reg         pslverr_q,           // APB error, unmapped address
   output reg         irq_q,               // Level interrupt
   input  wire        serial_in_pin,       // Serial data in
   output reg         serial_out_pin_o,    // Serial data out
   output reg         serial_out_pin_oe,   // Data out drive enable
   input  wire        shift_clock_pin_i,   // Shift clock pin level
   output reg         shift_clock_pin_o,   // Shift clock driven level
   output reg         shift_clock_pin_oe,  // Shift clock drive enable
   input  wire        select_n_pin         // Slave select, active low
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg                       en_q;
   reg                       idle_stop_q;
   reg                       rov_q;
   reg                       tbf_q;
   reg                       rbf_q;
   reg [`SSP_CON1_WIDTH-1:0] con1_q;
   reg [15:0]                txb_q;
   reg [15:0]                rxb_q;
   reg [15:0]                sr_q;
   reg                       busy_q;
   reg [5:0]                 edge_q;
   reg [4:0]                 bits_q;
   reg                       sck_prev_q;
   reg [`SSP_IRQ_WIDTH-1:0]  irq_stat_q;
   reg [`SSP_IRQ_WIDTH-1:0]  irq_mask_q;
   reg [31:0]                rd_data;
   reg                       rd_err;

   // ----------------------------------------------------------------
   // Pin synchronisers and master clock divider
   // ----------------------------------------------------------------
   wire [2:0] pins_s;
   wire       sdi_s;
   wire       sck_s;
   wire       sel_n_s;
   wire       tick;

   ssp_sync #(
      .W (3)
   ) u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .d       ({select_n_pin, shift_clock_pin_i, serial_in_pin}),
      .q       (pins_s)
   );

   assign sdi_s   = pins_s[0];
   assign sck_s   = pins_s[1];
   assign sel_n_s = pins_s[2];

   // Configuration fields
   wire master  = con1_q[`SSP_CON1_MASTER_ENABLE];
   wire w16     = con1_q[`SSP_CON1_WORD_WIDTH_SELECT];
   wire cke     = con1_q[`SSP_CON1_CLOCK_EDGE_SELECT];
   wire clock_idle_polarity     = con1_q[`SSP_CON1_CLOCK_IDLE_POLARITY];
   wire smp_end = master & con1_q[`SSP_CON1_INPUT_SAMPLE_PHASE];
   wire select_pin_enable    = con1_q[`SSP_CON1_SELECT_PIN_ENABLE];
   wire clock_pin_disable  = con1_q[`SSP_CON1_CLOCK_PIN_DISABLE];
   wire data_out_pin_disable  = con1_q[`SSP_CON1_DATA_OUT_PIN_DISABLE];

   // Idle stop freezes the engine instead of resetting it
   wire run = en_q & ~(idle_stop_q & cpu_idle);

   ssp_clkgen #(
      .HALF_DIV (HALF_DIV)
   ) u_clkgen (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .run     (run & master & busy_q),
      .tick_q  (tick)
   );

   // ----------------------------------------------------------------
   // Shift engine decode
   // ----------------------------------------------------------------
   wire [4:0] nbits = w16 ? `SSP_WORD_BITS : `SSP_BYTE_BITS;
   wire [5:0] nedge = {nbits, 1'b0};
   wire       out_hi = w16 ? sr_q[15] : sr_q[7];
   wire       out_nx = w16 ? sr_q[14] : sr_q[6];
   wire       tx_hi  = w16 ? txb_q[15] : txb_q[7];

   // Master: even edges leave the idle level, odd edges return to it
   wire m_go   = master & busy_q & run & tick;
   wire m_edge = m_go & (edge_q < nedge);
   wire m_fin  = m_go & (edge_q == nedge);

   // Slave: edges of the received clock, qualified by the select pin
   wire selected = ~select_pin_enable | ~sel_n_s;
   wire s_ok     = ~master & run & selected;
   wire s_lead   = s_ok & (sck_prev_q == clock_idle_polarity) & (sck_s != clock_idle_polarity);
   wire s_trail  = s_ok & (sck_prev_q != clock_idle_polarity) & (sck_s == clock_idle_polarity);

   wire lead  = master ? (m_edge & ~edge_q[0]) : s_lead;
   wire trail = master ? (m_edge & edge_q[0]) : s_trail;

   // Data changes on one edge; it is sampled on the other edge, or on the changing edge when smp_end is set
   wire chg     = cke ? trail : lead;
   wire cap_mid = (cke ? lead : trail) & ~smp_end;
   wire cap_end = smp_end & m_go & (edge_q != 6'd0) & (edge_q[0] == cke)
                  & (edge_q <= nedge);
   wire cap     = cap_mid | cap_end;
   wire last    = cap & (bits_q == nbits - 5'd1);

   wire [15:0] sr_cap = {sr_q[14:0], sdi_s};

   // Loading the holding stage into the shift register
   wire start = run & ~busy_q & tbf_q & (~master | ~clock_pin_disable);

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire acc      = psel & penable;
   wire done     = acc & pready_q;
   wire wr_done  = done & pwrite;
   wire rd_done  = done & ~pwrite;
   wire rd_buf   = rd_done & (paddr == `SSP_OFF_BUF);
   wire wr_buf   = wr_done & (paddr == `SSP_OFF_BUF);
   wire wr_stat  = wr_done & (paddr == `SSP_OFF_STAT);

   // A word arriving while the last is unread is dropped
   wire rx_ok = last & (~rbf_q | rd_buf);
   wire rx_ov = last & rbf_q & ~rd_buf;

   // Only the bits actually returned by a status read are cleared
   wire [`SSP_IRQ_WIDTH-1:0] irq_set = {rx_ov, start, rx_ok};
   wire [`SSP_IRQ_WIDTH-1:0] irq_clr =
      (rd_done & (paddr == `SSP_OFF_IRQ_STAT)) ? prdata_q[`SSP_IRQ_WIDTH-1:0]
                                                : {`SSP_IRQ_WIDTH{1'b0}};

   // Read data and error for the addressed register
   always @*
   begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      if (paddr == `SSP_OFF_STAT)
      begin
         rd_data[`SSP_STAT_MODULE_ENABLE] = en_q;
         rd_data[`SSP_STAT_IDLE_STOP]     = idle_stop_q;
         rd_data[`SSP_STAT_RX_OVERFLOW]   = rov_q;
         rd_data[`SSP_STAT_TX_FULL]       = tbf_q;
         rd_data[`SSP_STAT_RX_FULL]       = rbf_q;
      end
      else if (paddr == `SSP_OFF_CON1)
         rd_data[`SSP_CON1_WIDTH-1:0] = con1_q;
      else if (paddr == `SSP_OFF_BUF)
         rd_data[15:0] = rxb_q;
      else if (paddr == `SSP_OFF_IRQ_STAT)
         rd_data[`SSP_IRQ_WIDTH-1:0] = irq_stat_q;
      else if (paddr == `SSP_OFF_IRQ_MASK)
         rd_data[`SSP_IRQ_WIDTH-1:0] = irq_mask_q;
      else
         rd_err = 1'b1;
   end

   // ----------------------------------------------------------------
   // APB slave: one wait state, answer registered
   // ----------------------------------------------------------------
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
      else if (clk_en)
      begin
         pready_q <= acc & ~pready_q;
         if (acc & ~pready_q)
         begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_data;
            pslverr_q <= rd_err;
         end
         else
         begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Software registers and flags; hardware set wins over clear
   // ----------------------------------------------------------------
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         en_q        <= 1'b0;
         idle_stop_q <= 1'b0;
         rov_q       <= 1'b0;
         tbf_q       <= 1'b0;
         rbf_q       <= 1'b0;
         con1_q      <= `SSP_CON1_RESET;
         txb_q       <= 16'h0000;
         rxb_q       <= 16'h0000;
         irq_stat_q  <= {`SSP_IRQ_WIDTH{1'b0}};
         irq_mask_q  <= {`SSP_IRQ_WIDTH{1'b0}};
         irq_q       <= 1'b0;
      end
      else if (clk_en)
      begin
         if (wr_stat)
         begin
            en_q        <= pwdata[`SSP_STAT_MODULE_ENABLE];
            idle_stop_q <= pwdata[`SSP_STAT_IDLE_STOP];
         end
         if (wr_done & (paddr == `SSP_OFF_CON1))
            con1_q <= pwdata[`SSP_CON1_WIDTH-1:0];
         if (wr_done & (paddr == `SSP_OFF_IRQ_MASK))
            irq_mask_q <= pwdata[`SSP_IRQ_WIDTH-1:0];
         // Overflow clears when software writes a zero into it
         if (rx_ov)
            rov_q <= 1'b1;
         else if (wr_stat & ~pwdata[`SSP_STAT_RX_OVERFLOW])
            rov_q <= 1'b0;
         // A buffer write landing with a start keeps the new word pending
         if (wr_buf)
         begin
            txb_q <= pwdata[15:0];
            tbf_q <= 1'b1;
         end
         else if (start)
            tbf_q <= 1'b0;
         if (rx_ok)
         begin
            rxb_q <= w16 ? sr_cap : {8'h00, sr_cap[7:0]};
            rbf_q <= 1'b1;
         end
         else if (rd_buf)
            rbf_q <= 1'b0;
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
         irq_q      <= |(irq_stat_q & irq_mask_q);
      end
   end

   // ----------------------------------------------------------------
   // Shift engine
   // ----------------------------------------------------------------
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         sr_q       <= 16'h0000;
         busy_q     <= 1'b0;
         edge_q     <= 6'd0;
         bits_q     <= 5'd0;
         sck_prev_q <= 1'b0;
         shift_clock_pin_o <= 1'b0;
         serial_out_pin_o  <= 1'b0;
      end
      else if (clk_en)
      begin
         sck_prev_q <= sck_s;
         if (!en_q)
         begin
            busy_q <= 1'b0;
            edge_q <= 6'd0;
            bits_q <= 5'd0;
            shift_clock_pin_o <= clock_idle_polarity;
         end
         else if (start)
         begin
            sr_q   <= txb_q;
            busy_q <= 1'b1;
            edge_q <= 6'd0;
            bits_q <= 5'd0;
            // Late-change mode needs the first bit out before any edge
            if (cke)
               serial_out_pin_o <= tx_hi;
         end
         else
         begin
            if (m_edge)
            begin
               shift_clock_pin_o <= ~shift_clock_pin_o;
               edge_q <= edge_q + 6'd1;
            end
            else if (m_fin)
            begin
               busy_q <= 1'b0;
               edge_q <= 6'd0;
               shift_clock_pin_o <= clock_idle_polarity;
            end
            else if (~busy_q & run)
               shift_clock_pin_o <= clock_idle_polarity;
            // A slave word starts at a leading edge; the closing trailing
            // edge must not re-arm it, or no later word could be loaded
            if (s_lead & ~busy_q)
               busy_q <= 1'b1;
            if (chg)
               serial_out_pin_o <= cap ? out_nx : out_hi;
            if (cap)
            begin
               sr_q   <= sr_cap;
               bits_q <= last ? 5'd0 : bits_q + 5'd1;
               if (last & ~master)
                  busy_q <= 1'b0;
            end
            else if (~master & select_pin_enable & sel_n_s)
               bits_q <= 5'd0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin ownership
   // ----------------------------------------------------------------
   // Clock pin is released as plain I/O when the clock pin disable bit is set
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         shift_clock_pin_oe <= 1'b0;
         serial_out_pin_oe  <= 1'b0;
      end
      else if (clk_en)
      begin
         shift_clock_pin_oe <= en_q & master & ~clock_pin_disable;
         serial_out_pin_oe  <= en_q & ~data_out_pin_disable & (master | selected);
      end
   end

endmodule // ssp_core

// ==== rtl/ssp_sync.v ====
// Two flip-flop synchroniser for a group of asynchronous pin inputs.
// Assumes the inputs are independent levels; no bus coherence is kept.
`timescale 1ns/1ps

module ssp_sync #(
   parameter W = 3
) (
   input  wire         ref_clk,  // System clock
   input  wire         rst_n,    // Synchronous reset, active low
   input  wire         clk_en,   // Freezes the stages while low
   input  wire [W-1:0] d,        // Asynchronous inputs
   output wire [W-1:0] q         // Synchronised outputs
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // ---------------------------------------------------------------
   // Two stages; only the second stage leaves this module
   // ---------------------------------------------------------------
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end
      else if (clk_en)
      begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;

endmodule // ssp_sync

// ==== test/ssp_core_props.sv ====
// Checker for the serial port core: APB answer timing and clock pacing.
// Sees only the core's ports; attached by the bind at the foot.
`timescale 1ns/1ps
module ssp_core_props #(
   parameter [7:0] HALF_DIV = 8'd4  // Half period in ref_clk cycles
) (
   input wire        ref_clk,          // System clock
   input wire        rst_n,            // Reset, active low
   input wire        psel,             // APB select
   input wire        penable,          // APB access phase
   input wire        pwrite,           // APB direction
   input wire [31:0] prdata_q,         // APB read data
   input wire        pready_q,         // APB ready
   input wire        pslverr_q,        // APB error
   input wire        shift_clock_pin_o // Master shift clock
);
   reg [7:0] gap_q;  // Cycles since the shift clock moved
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // Saturates, so a long idle spell never wraps to a short gap
   always @(posedge ref_clk)
   begin
      if (!rst_n || $changed(shift_clock_pin_o))
         gap_q <= 8'h00;
      else
         gap_q <= gap_q + {7'h00, ~&gap_q};
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_wait;
      psel && penable && !pready_q;
   endsequence
   sequence s_done;
      pready_q ##1 !pready_q;
   endsequence
   ready_after_access_a: assert property (s_wait |=> s_done)
      else $error("ready missing after access");
   ready_has_cause_a: assert property (pready_q |-> $past(psel && penable))
      else $error("ready without access");
   error_with_ready_a: assert property (pslverr_q |-> pready_q)
      else $error("error outside ready");
   error_data_zero_a: assert property (pslverr_q && !pwrite |-> prdata_q == 32'h0)
      else $error("error read data not zero");
   upper_half_zero_a: assert property (pready_q && !pwrite |-> prdata_q[31:16] == 16'h0)
      else $error("upper read bits not zero");
   read_data_hold_a: assert property (!(psel && penable) |=> $stable(prdata_q))
      else $error("read data moved between accesses");
   error_has_cause_a: assert property ($rose(pslverr_q) |-> $past(psel && penable))
      else $error("error without access");
   clock_gap_a: assert property ($changed(shift_clock_pin_o) |-> gap_q >= HALF_DIV - 8'd1)
      else $error("shift clock half period too short");
endmodule // ssp_core_props

bind ssp_core ssp_core_props #(.HALF_DIV(HALF_DIV)) ssp_core_props_i (.ref_clk(ref_clk),
   .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata_q(prdata_q),
   .pready_q(pready_q), .pslverr_q(pslverr_q), .shift_clock_pin_o(shift_clock_pin_o));

// ==== test/ssp_peer.sv ====
// Behavioural serial peripheral on the far side of the link.
// Works whichever end drives sck; tx_word is taken on every change of load.
`timescale 1ns/1ps
module ssp_peer (
   input  wire        sck,     // Shift clock on the wire
   input  wire        cpol,    // Idle clock level
   input  wire        wide,    // Sixteen bit words when high
   input  wire        mosi,    // Data from the core
   output wire        miso,    // Data to the core
   input  wire        load,    // Any change loads tx_word
   input  wire [15:0] tx_word, // Next word to send
   output reg  [15:0] rx_word  // Received bits, newest in bit 0
);
   reg [15:0] sh;  // Outgoing word, MSB on the line
   assign miso = wide ? sh[15] : sh[7];
   always @(load)
      sh = tx_word;
   // Sample leaving idle, shift back to idle; no select line exists
   always @(sck)
   begin
      if (sck !== cpol)
         rx_word = {rx_word[14:0], mosi};
      else
         sh = sh << 1;
   end
endmodule // ssp_peer

// ==== test/tb_spi_serial_port_core.sv ====
// Self-checking bench: APB master, core in master and slave modes, peer model.
// Assumes checker and peer files are compiled first.
`timescale 1ns/1ps
`include "ssp_consts.vh"
module tb_spi_serial_port_core;
   localparam [31:0] EN = 32'h1 << `SSP_STAT_MODULE_ENABLE;
   localparam [31:0] SIDL = 32'h1 << `SSP_STAT_IDLE_STOP;
   localparam [31:0] ROV = 32'h1 << `SSP_STAT_RX_OVERFLOW;
   localparam [31:0] TBF = 32'h1 << `SSP_STAT_TX_FULL;
   localparam [31:0] RBF = 32'h1 << `SSP_STAT_RX_FULL;
   localparam [31:0] MST = (32'h1 << `SSP_CON1_MASTER_ENABLE) | 32'h100;
   localparam [31:0] CDIS = 32'h1 << `SSP_CON1_CLOCK_PIN_DISABLE;
   localparam [31:0] POL = 32'h1 << `SSP_CON1_CLOCK_IDLE_POLARITY;
   localparam [31:0] W16 = 32'h1 << `SSP_CON1_WORD_WIDTH_SELECT;
   reg         ref_clk = 1'b0, rst_n = 1'b0, cpu_idle = 1'b0;
   reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg  [7:0]  paddr = 8'h00;
   reg  [31:0] pwdata = 32'h0, r;
   reg         cpol = 1'b0, wide = 1'b0, load = 1'b0, lck = 1'b0, slverr;
   reg  [15:0] ld_word = 16'h0;
   integer     bad_count = 0, n_checks = 0, cyc = 0;
   wire [31:0] prdata_q;
   wire        pready_q, pslverr_q, irq_q, so_o, so_oe, sck_o, sck_oe, miso;
   wire [15:0] rx_word;
   wire        sck = sck_oe ? sck_o : (lck ^ cpol);  // Bench clock when slave
   wire        mosi = so_oe ? so_o : 1'b1;   // Pulled up when free
   ssp_core ssp_core_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
      .cpu_idle(cpu_idle), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
      .pslverr_q(pslverr_q), .irq_q(irq_q), .serial_in_pin(miso),
      .serial_out_pin_o(so_o), .serial_out_pin_oe(so_oe), .shift_clock_pin_i(sck),
      .shift_clock_pin_o(sck_o), .shift_clock_pin_oe(sck_oe), .select_n_pin(1'b1));
   ssp_peer ssp_peer_i (.sck(sck), .cpol(cpol), .wide(wide), .mosi(mosi),
      .miso(miso), .load(load), .tx_word(ld_word), .rx_word(rx_word));
   // 40 MHz system clock
   always #12.5 ref_clk = ~ref_clk;
   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task chk(input [31:0] got, input [31:0] exp);
   begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
         bad_count = bad_count + 1;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   // Two idle edges at the end let registered side effects settle
   task apb(input w, input [7:0] a, input [31:0] d);
   begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready_q !== 1'b1)
         @(posedge ref_clk);
      r = prdata_q;
      slverr = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge ref_clk);
   end
   endtask
   task rd(input [7:0] a, input [31:0] exp);
   begin
      apb(1'b0, a, 32'h0);
      chk(r, exp);
   end
   endtask
   // Polls status; the tail covers the last half period of the frame
   task wt(input [31:0] bits);
   begin
      r = 32'h0;
      while ((r & bits) !== bits)
         apb(1'b0, `SSP_OFF_STAT, 32'h0);
      repeat (8) @(posedge ref_clk);
   end
   endtask
   task send(input [15:0] peer_w, input [31:0] core_w);
   begin
      ld_word <= peer_w;
      load <= ~load;
      apb(1'b1, `SSP_OFF_BUF, core_w);
   end
   endtask
   task end_of_test;
   begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end
   endtask
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task t_regs;
   begin
      rd(`SSP_OFF_STAT, 0);
      rd(`SSP_OFF_CON1, 0);
      rd(`SSP_OFF_IRQ_STAT, 0);
      rd(`SSP_OFF_IRQ_MASK, 0);
      rd(8'h14, 0);
      chk(slverr, 1);
   end
   endtask
   task t_byte;
   begin
      apb(1'b1, `SSP_OFF_CON1, MST | CDIS);
      apb(1'b1, `SSP_OFF_STAT, EN);
      send(16'h003c, 32'ha5);
      repeat (20) @(posedge ref_clk);
      rd(`SSP_OFF_STAT, EN | TBF);
      apb(1'b1, `SSP_OFF_CON1, MST);
      wt(RBF);
      rd(`SSP_OFF_STAT, EN | RBF);
      chk(rx_word[7:0], 8'ha5);
      rd(`SSP_OFF_BUF, 32'h3c);
      rd(`SSP_OFF_STAT, EN);
   end
   endtask
   task t_ovf;
   begin
      apb(1'b1, `SSP_OFF_IRQ_MASK, 32'h4);
      send(16'h0011, 32'h01);
      wt(RBF);
      chk(irq_q, 0);
      send(16'h0022, 32'h02);
      wt(ROV);
      rd(`SSP_OFF_STAT, EN | ROV | RBF);
      chk(irq_q, 1);
      rd(`SSP_OFF_BUF, 32'h11);
      apb(1'b1, `SSP_OFF_STAT, EN);
      rd(`SSP_OFF_STAT, EN);
      apb(1'b0, `SSP_OFF_IRQ_STAT, 32'h0);
      chk(r[2], 1);
      chk(irq_q, 0);
   end
   endtask
   task t_wide;
   begin
      apb(1'b1, `SSP_OFF_STAT, 32'h0);
      chk({so_oe, sck_oe}, 2'b00);
      cpol <= 1'b1;
      wide <= 1'b1;
      apb(1'b1, `SSP_OFF_CON1, MST | POL | W16);
      apb(1'b1, `SSP_OFF_STAT, EN);
      chk({sck_oe, sck_o}, 2'b11);
      send(16'hbeef, 32'h5a96);
      wt(RBF);
      rd(`SSP_OFF_BUF, 32'hbeef);
      chk(rx_word, 16'h5a96);
   end
   endtask
   task t_idle;
   begin
      apb(1'b1, `SSP_OFF_STAT, EN | SIDL);
      cpu_idle <= 1'b1;
      send(16'h1234, 32'h4321);
      repeat (40) @(posedge ref_clk);
      rd(`SSP_OFF_STAT, EN | SIDL | TBF);
      cpu_idle <= 1'b0;
      wt(RBF);
      rd(`SSP_OFF_BUF, 32'h1234);
   end
   endtask
   // Bench plays link master, 200 ns clock; second word must load at once
   task t_slave;
   begin
      apb(1'b1, `SSP_OFF_CON1, POL | W16 | 32'h100);
      send(16'hc3a5, 32'h6e17);
      repeat (32)
      begin
         repeat (4) @(posedge ref_clk);
         lck <= ~lck;
      end
      repeat (8) @(posedge ref_clk);
      rd(`SSP_OFF_BUF, 32'hc3a5);
      chk(rx_word, 16'h6e17);
      send(16'h0000, 32'h0);
      rd(`SSP_OFF_STAT, EN | SIDL);
      apb(1'b1, `SSP_OFF_CON1, POL | W16 | 32'h100 | (32'h1 << `SSP_CON1_DATA_OUT_PIN_DISABLE));
      chk(so_oe, 0);
   end
   endtask
   // Run ceiling well above the thousand or so cycles needed
   always @(posedge ref_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         bad_count = bad_count + 1;
         end_of_test;
      end
   end
   initial
   begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_regs;
      t_byte;
      t_ovf;
      t_wide;
      t_idle;
      t_slave;
      end_of_test;
   end
endmodule // tb_spi_serial_port_core
